// ---- bench/tb.sv ----
// self-checking bench for the uart command sequencer
`timescale 1ns/1ps
`include "ucs_cfg.svh"
module tb;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [15:0] i_sample = 16'h0000;
    logic rx_line;
    logic pin2_wire;
    logic o_tx, o_pin2_out, o_pin2_oe_n, o_sleep, o_converting;
    logic o_inputs_shorted, o_temp_sense_select, o_gain_amplifier_on, o_result_ready_flag;
    logic [3:0] o_input_select_field;
    logic [2:0] o_gain_amplifier, o_sample_rate_select;
    int mismatches = 0;
    int check_count = 0;
    int seed = 32'hCED06A96;
    logic [7:0] regs [5];
    logic [7:0] exp_q [$];

    ////////////////////////////////////////
    always #2.5 i_clk = ~i_clk;
    // pin2 has a pull-up while the device leaves it as an input
    assign pin2_wire = (o_pin2_oe_n === 1'b0) ? o_pin2_out : 1'b1;

    ucs_sequencer dut_u (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_rx(rx_line), .o_tx(o_tx),
        .i_sample(i_sample), .i_pin2_in(pin2_wire), .o_pin2_out(o_pin2_out),
        .o_pin2_oe_n(o_pin2_oe_n), .o_sleep(o_sleep), .o_converting(o_converting),
        .o_inputs_shorted(o_inputs_shorted), .o_temp_sense_select(o_temp_sense_select),
        .o_input_select_field(o_input_select_field), .o_gain_amplifier(o_gain_amplifier),
        .o_gain_amplifier_on(o_gain_amplifier_on), .o_sample_rate_select(o_sample_rate_select),
        .o_result_ready_flag(o_result_ready_flag)
    );

    ucs_host_model #(.POWERUP_CYC(200)) host_u (
        .i_clk(i_clk), .i_tx(o_tx), .i_pin2(pin2_wire), .o_rx(rx_line)
    );

    ////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // decoded config outputs against the register model
    task automatic chk_cfg();
        check(o_input_select_field, regs[0][7:4], "input select");
        check(o_inputs_shorted, regs[0][7:4] == 4'hE, "shorted");
        check(o_gain_amplifier, regs[0][3:1], "gain");
        check(o_gain_amplifier_on, !regs[0][0], "amp on");
        check(o_sample_rate_select, regs[1][7:5], "rate");
        check(o_temp_sense_select, regs[1][0], "temp sensor");
        check(o_pin2_oe_n, !regs[4][3], "pin2 direction");
    endtask : chk_cfg

    task automatic cmd(input logic [7:0] op);
        host_u.send_byte(`UCS_SYNC_BYTE);
        host_u.send_byte(op);
    endtask : cmd

    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        cmd({4'h4, idx, 1'b0});
        host_u.send_byte(d);
        regs[idx] = d;
        chk_cfg();
    endtask : wr

    // reply starts inside the opcode's stop bit, so listen alongside
    task automatic rd(input logic [7:0] op, input int n);
        logic [7:0] b;
        logic stop;
        logic ok;
        host_u.send_byte(`UCS_SYNC_BYTE);
        fork
            host_u.send_byte(op);
            for (int i = 0; i < n; i++) begin
                host_u.recv_byte(b, stop, ok);
                check(ok, 1'b1, "reply missing");
                check(stop, 1'b1, "stop bit");
                check(b, exp_q.pop_front(), "reply byte");
            end
        join
    endtask : rd

    ////////////////////////////////////////
    initial begin
        logic ok;
        for (int i = 0; i < 5; i++) begin
            regs[i] = 8'h00;
        end
        repeat (20) @(posedge i_clk);
        @(negedge i_clk);
        i_arst_n = 1'b1;
        host_u.power_up_wait();
        check(o_tx, 1'b1, "tx idle");
        check(o_converting, 1'b0, "idle after reset");
        chk_cfg();
        // a lone opcode outside a frame must not start decoding
        host_u.send_byte(8'h42);
        // shorted inputs come first, as for an offset reading
        wr(3'd0, {4'hE, 4'($random(seed))});
        wr(3'd0, 8'h0A);
        wr(3'd1, 8'h09);
        wr(3'd1, 8'h08);
        wr(3'd4, 8'h48);
        exp_q.push_back(8'h08);
        rd(8'h22, 1);
        exp_q.push_back(8'($random(seed)));
        wr(3'd2, exp_q[0]);
        rd(8'h24, 1);
        wr(3'd2, 8'h00);
        wr(3'd3, 8'h00);
        i_sample = 16'($random(seed));
        exp_q.push_back(i_sample[15:8]);
        exp_q.push_back(i_sample[7:0]);
        cmd(`UCS_CMD_START);
        check(o_converting, 1'b1, "running");
        host_u.wait_ready(ok);
        check(ok, 1'b1, "ready edge");
        check(o_tx, 1'b1, "no unsolicited send");
        rd(`UCS_CMD_RDATA, 2);
        // new input, then one full conversion period so it is captured
        i_sample = 16'($random(seed));
        exp_q.push_back(i_sample[15:8]);
        exp_q.push_back(i_sample[7:0]);
        repeat (10010) @(negedge i_clk);
        check(o_result_ready_flag, 1'b0, "unread result");
        rd(`UCS_CMD_RDATA, 2);
        cmd(`UCS_CMD_SLEEP);
        check(o_sleep, 1'b1, "asleep");
        check(o_converting, 1'b0, "stopped");
        cmd(`UCS_CMD_RESET);
        host_u.rst_wait();
        for (int i = 0; i < 5; i++) begin
            regs[i] = 8'h00;
        end
        check(o_sleep, 1'b0, "awake after reset");
        chk_cfg();
        report_and_stop();
    end

    // about 45 frames of 1000 cycles and two conversion waits, plus margin
    initial begin
        repeat (90000) @(posedge i_clk);
        mismatches++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule : tb

// ---- bench/ucs_host_model.sv ----
// host microcontroller model: 8-n-1 uart and ready-pin watcher
`timescale 1ns/1ps
`include "ucs_cfg.svh"
module ucs_host_model #(
    parameter int POWERUP_CYC = 120000
) (
    input wire logic i_clk,
    input wire logic i_tx,
    input wire logic i_pin2,
    output logic o_rx
);
    ////////////////////////////////////////
    // line idles high outside frames
    initial o_rx = 1'b1;

    // supply settle; bench passes a short value to keep the run small
    task automatic power_up_wait();
        repeat (POWERUP_CYC) @(negedge i_clk);
    endtask : power_up_wait

    // nothing may be sent until the device leaves reset
    task automatic rst_wait();
        repeat (`UCS_RST_HOLD_CYC) @(negedge i_clk);
    endtask : rst_wait

    // start, eight data bits lsb first, one stop, no parity
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_rx = fr[i];
            repeat (`UCS_BAUD_DIV) @(negedge i_clk);
        end
    endtask : send_byte

    // bounded hunt for a start bit, then sample each bit mid-cell
    task automatic recv_byte(output logic [7:0] b, output logic stop, output logic ok);
        ok = 1'b0;
        b = 8'h00;
        for (int n = 0; n < 16 * `UCS_BAUD_DIV && !ok; n++) begin
            @(negedge i_clk);
            ok = (i_tx === 1'b0);
        end
        repeat (`UCS_BAUD_DIV / 2) @(negedge i_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (`UCS_BAUD_DIV) @(negedge i_clk);
            b[i] = i_tx;
        end
        repeat (`UCS_BAUD_DIV) @(negedge i_clk);
        stop = i_tx;
    endtask : recv_byte

    // falling edge of the ready pin is the cue to read
    task automatic wait_ready(output logic ok);
        logic was_high;
        ok = 1'b0;
        was_high = 1'b0;
        for (int n = 0; n < 30000 && !ok; n++) begin
            @(negedge i_clk);
            ok = was_high && (i_pin2 === 1'b0);
            was_high = (i_pin2 === 1'b1);
        end
    endtask : wait_ready
endmodule : ucs_host_model

// ---- logic/ucs_cfg.svh ----
// constants for the uart command sequencer
`ifndef UCS_CFG_SVH
`define UCS_CFG_SVH
`define UCS_SYNC_BYTE 8'h55
`define UCS_CMD_RESET 8'h06
`define UCS_CMD_START 8'h08
`define UCS_CMD_SLEEP 8'h02
`define UCS_CMD_RDATA 8'h10
`define UCS_CMD_REGISTER_WRITE_CMD_HI 4'h4
`define UCS_CMD_REGISTER_READ_CMD_HI 4'h2
`define UCS_REG_COUNT 5
`define UCS_REG0_RESET 8'h00
`define UCS_REG1_RESET 8'h00
`define UCS_REG2_RESET 8'h00
`define UCS_REG3_RESET 8'h00
`define UCS_REG4_RESET 8'h00
`define UCS_MUX_POS 7:4
`define UCS_MUX_SHORT 4'hE
`define UCS_GAIN_POS 3:1
`define UCS_PGA_BYPASS_BIT 0
`define UCS_CONT_BIT 3
`define UCS_TS_BIT 0
`define UCS_DR_POS 7:5
`define UCS_RESULT_READY_FLAG_SEL_BIT 3
`define UCS_RESULT_READY_FLAG_DIR_BIT 6
`define UCS_BAUD_DIV 16'd100 // clocks per serial bit; host must match this fixed rate
`define UCS_CONV_CYC 24'd10000
`define UCS_RST_HOLD_CYC 16'd100
`define UCS_FIFO_DEPTH 16
`define UCS_FIFO_AW 4
`endif

// ---- logic/ucs_fifo.sv ----
// transmit byte fifo
`timescale 1ns/1ps
module ucs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_clr,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic full;
    logic empty;
    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign empty = (wr_q == rd_q);
    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data = mem_q[rd_q[AW-1:0]];
    // storage writes, no reset needed on data
    always_ff @(posedge i_clk) begin
        if (i_valid && !full) begin
            mem_q[wr_q[AW-1:0]] <= i_data;
        end
    end
    // pointers, clear drops pending bytes
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else if (i_clr) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (i_valid && !full) begin
                wr_q <= wr_q + 1'b1;
            end
            if (i_ready && !empty) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule : ucs_fifo

// ---- logic/ucs_pkg.sv ----
// types for the uart command sequencer
package ucs_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_WDATA = 3'b011,
        ST_RST = 3'b010,
        ST_RESP = 3'b110
    } ucs_state_type;
    typedef struct packed {
        logic [3:0] mux;
        logic [2:0] gain;
        logic pga_bypass;
    } ucs_input_cfg_type;
endpackage : ucs_pkg

// ---- logic/ucs_sequencer.sv ----
// command interpreter of the uart converter front end
`timescale 1ns/1ps
`include "ucs_cfg.svh"
// Summary of operation
// - serial framing is 8-N-1 both ways
// - byte 0x55 opens every command frame
// - 0x06 resets device; host waits afterwards
// - sync, 0x40 | r<<1, data writes register r
// - sync, 0x20 | r<<1 returns register r contents
// - 0x08 starts; continuous mode keeps converting
// - pin2 low when new result ready
// - sync, 0x10 returns result as two bytes
// - 0x02 stops conversions, enters sleep
// - input select 1110 shorts inputs mid-supply
// - temp sense bit selects internal sensor
// - reg0 0x0A: AIN0/AIN1, gain 32, amplifier on
// - reg1 0x08: 20 sps, continuous, internal ref
// - reg2 0x00: counter, check, burnout, current off
// - reg3 0x00: currents unrouted, manual read mode
// - reg4 0x48: pin2 becomes ready output
// - after reset pin2 is general input
module ucs_sequencer
    import ucs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_rx,
    output logic o_tx,
    input wire logic [15:0] i_sample,
    input wire logic i_pin2_in,
    output logic o_pin2_out,
    output logic o_pin2_oe_n,
    output logic o_sleep,
    output logic o_converting,
    output logic o_inputs_shorted,
    output logic o_temp_sense_select,
    output logic [3:0] o_input_select_field,
    output logic [2:0] o_gain_amplifier,
    output logic o_gain_amplifier_on,
    output logic [2:0] o_sample_rate_select,
    output logic o_result_ready_flag
);
    logic rst_s1_q;
    logic rst_n;
    ucs_state_type state_q;
    logic [7:0] regs_q [`UCS_REG_COUNT];
    logic [2:0] addr_q;
    logic [15:0] result_q;
    logic conv_on_q;
    logic [23:0] conv_cnt_q;
    logic [15:0] rst_cnt_q;
    logic soft_rst;
    logic rx_valid;
    logic [7:0] rx_data;
    logic push_valid;
    logic [7:0] push_data;
    logic push_ready;
    logic tx_valid;
    logic tx_ready;
    logic [7:0] tx_data;
    logic [1:0] resp_left_q;
    logic [15:0] resp_q;
    logic conv_done;
    ucs_input_cfg_type in_cfg;

    ////////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    ucs_uart u_uart (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_rx(i_rx),
        .o_rx_valid(rx_valid),
        .o_rx_data(rx_data),
        .i_tx_valid(tx_valid),
        .o_tx_ready(tx_ready),
        .i_tx_data(tx_data),
        .o_tx(o_tx)
    );

    // response bytes queue here; the command decoder stalls while it is full
    ucs_fifo #(.WIDTH(8), .DEPTH(`UCS_FIFO_DEPTH), .AW(`UCS_FIFO_AW)) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_clr(soft_rst),
        .i_valid(push_valid),
        .o_ready(push_ready),
        .i_data(push_data),
        .o_valid(tx_valid),
        .i_ready(tx_ready),
        .o_data(tx_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // command decoder
    assign soft_rst = (state_q == ST_RST);
    assign push_valid = (state_q == ST_RESP);
    assign push_data = (resp_left_q == 2'd2) ? resp_q[15:8] : resp_q[7:0];

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            addr_q <= 3'h0;
            resp_q <= 16'h0000;
            resp_left_q <= 2'd0;
            rst_cnt_q <= 16'h0000;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (rx_valid && rx_data == `UCS_SYNC_BYTE) begin
                        state_q <= ST_CMD;
                    end
                    // any other byte is dropped here
                end
                ST_CMD: begin
                    if (rx_valid) begin
                        addr_q <= rx_data[3:1]; // register index sits in opcode bits 3:1
                        state_q <= ST_IDLE;
                        if (rx_data == `UCS_CMD_RESET) begin
                            state_q <= ST_RST;
                            rst_cnt_q <= `UCS_RST_HOLD_CYC;
                        end else if (rx_data == `UCS_CMD_RDATA) begin
                            resp_q <= result_q;
                            resp_left_q <= 2'd2;
                            state_q <= ST_RESP;
                        end else if (rx_data[7:4] == `UCS_CMD_REGISTER_WRITE_CMD_HI) begin
                            state_q <= ST_WDATA;
                        end else if (rx_data[7:4] == `UCS_CMD_REGISTER_READ_CMD_HI) begin
                            // out-of-range reads return zero
                            resp_q <= {8'h00, (rx_data[3:1] < 3'd5) ? regs_q[rx_data[3:1]] : 8'h00};
                            resp_left_q <= 2'd1;
                            state_q <= ST_RESP;
                        end
                    end
                end
                ST_WDATA: begin
                    if (rx_valid) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_RST: begin
                    // received bytes ignored until the hold expires
                    if (rst_cnt_q == 16'h0000) begin
                        state_q <= ST_IDLE;
                    end else begin
                        rst_cnt_q <= rst_cnt_q - 16'h0001;
                    end
                end
                ST_RESP: begin
                    if (push_ready) begin
                        resp_left_q <= resp_left_q - 2'd1;
                        if (resp_left_q == 2'd1) begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers, register index is opcode bits 3:1
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            regs_q[0] <= `UCS_REG0_RESET;
            regs_q[1] <= `UCS_REG1_RESET;
            regs_q[2] <= `UCS_REG2_RESET;
            regs_q[3] <= `UCS_REG3_RESET;
            regs_q[4] <= `UCS_REG4_RESET;
        end else if (soft_rst) begin
            regs_q[0] <= `UCS_REG0_RESET;
            regs_q[1] <= `UCS_REG1_RESET;
            regs_q[2] <= `UCS_REG2_RESET;
            regs_q[3] <= `UCS_REG3_RESET;
            regs_q[4] <= `UCS_REG4_RESET;
        end else if (state_q == ST_WDATA && rx_valid && addr_q < 3'd5) begin
            // indices past the last register drop the data byte
            regs_q[addr_q] <= rx_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // conversion engine: fixed period stand-in for the modulator
    assign conv_done = conv_on_q && (conv_cnt_q == 24'h000000);

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_on_q <= 1'b0;
            conv_cnt_q <= 24'h000000;
            result_q <= 16'h0000;
            o_sleep <= 1'b0;
        end else if (soft_rst) begin
            conv_on_q <= 1'b0;
            o_sleep <= 1'b0;
        end else if (state_q == ST_CMD && rx_valid && rx_data == `UCS_CMD_SLEEP) begin
            conv_on_q <= 1'b0;
            o_sleep <= 1'b1;
        end else if (state_q == ST_CMD && rx_valid && rx_data == `UCS_CMD_START) begin
            conv_on_q <= 1'b1;
            o_sleep <= 1'b0;
            conv_cnt_q <= `UCS_CONV_CYC;
        end else if (conv_on_q) begin
            if (conv_done) begin
                result_q <= i_sample;
                conv_cnt_q <= `UCS_CONV_CYC;
                conv_on_q <= regs_q[1][`UCS_CONT_BIT]; // single shot stops
            end else begin
                conv_cnt_q <= conv_cnt_q - 24'h000001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ready flag: low on new result, high again once read
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_result_ready_flag <= 1'b1;
        end else if (conv_done) begin
            o_result_ready_flag <= 1'b0; // set wins over clear
        end else if (soft_rst || (state_q == ST_CMD && rx_valid && rx_data == `UCS_CMD_RDATA)) begin
            o_result_ready_flag <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // analog control outputs decoded from registers
    assign in_cfg = regs_q[0];

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_pin2_out <= 1'b1;
            o_pin2_oe_n <= 1'b1;
            o_converting <= 1'b0;
            o_inputs_shorted <= 1'b0;
            o_temp_sense_select <= 1'b0;
            o_input_select_field <= 4'h0;
            o_gain_amplifier <= 3'h0;
            o_gain_amplifier_on <= 1'b0;
            o_sample_rate_select <= 3'h0;
        end else begin
            // pin2 drives only when selected as ready output
            o_pin2_oe_n <= !regs_q[4][`UCS_RESULT_READY_FLAG_SEL_BIT];
            o_pin2_out <= o_result_ready_flag;
            o_converting <= conv_on_q;
            o_inputs_shorted <= (in_cfg.mux == `UCS_MUX_SHORT);
            o_temp_sense_select <= regs_q[1][`UCS_TS_BIT];
            o_input_select_field <= in_cfg.mux;
            o_gain_amplifier <= in_cfg.gain;
            o_gain_amplifier_on <= !in_cfg.pga_bypass;
            o_sample_rate_select <= regs_q[1][`UCS_DR_POS];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_SYNC_FIRST: assert property (@(posedge i_clk) disable iff (!rst_n)
        (state_q == ST_IDLE && rx_valid && rx_data != `UCS_SYNC_BYTE) |=> state_q == ST_IDLE)
        else $error("non-sync byte left idle");
    AST_SYNC_OPEN: assert property (@(posedge i_clk) disable iff (!rst_n)
        (state_q == ST_IDLE && rx_valid && rx_data == `UCS_SYNC_BYTE) |=> state_q == ST_CMD)
        else $error("sync byte not accepted");
    AST_RESET_CMD: assert property (@(posedge i_clk) disable iff (!rst_n)
        (state_q == ST_CMD && rx_valid && rx_data == `UCS_CMD_RESET) |=> ##1 !conv_on_q)
        else $error("reset command left conversion running");
    AST_WRITE: assert property (@(posedge i_clk) disable iff (!rst_n)
        (state_q == ST_WDATA && rx_valid && addr_q == 3'd0) |=> regs_q[0] == $past(rx_data))
        else $error("register write lost");
    AST_WRITE_PIN: assert property (@(posedge i_clk) disable iff (!rst_n)
        (state_q == ST_WDATA && rx_valid && addr_q == 3'd4) |=> regs_q[4] == $past(rx_data))
        else $error("pin function write lost");
    AST_READ: assert property (@(posedge i_clk) disable iff (!rst_n)
        (state_q == ST_CMD && rx_valid && rx_data[7:4] == `UCS_CMD_REGISTER_READ_CMD_HI) |=> state_q == ST_RESP)
        else $error("read did not respond");
    AST_START: assert property (@(posedge i_clk) disable iff (!rst_n)
        (state_q == ST_CMD && rx_valid && rx_data == `UCS_CMD_START) |=> conv_on_q ##1 o_converting)
        else $error("start did not begin conversion");
    AST_READY_LOW: assert property (@(posedge i_clk) disable iff (!rst_n)
        conv_done |=> !o_result_ready_flag ##1 (o_pin2_out == 1'b0))
        else $error("ready flag not low after result");
    AST_RDATA_TWO: assert property (@(posedge i_clk) disable iff (!rst_n)
        (state_q == ST_CMD && rx_valid && rx_data == `UCS_CMD_RDATA) |=> resp_left_q == 2'd2)
        else $error("data read not two bytes");
    AST_SLEEP: assert property (@(posedge i_clk) disable iff (!rst_n)
        (state_q == ST_CMD && rx_valid && rx_data == `UCS_CMD_SLEEP) |=> o_sleep && !conv_on_q)
        else $error("sleep command ignored");
    AST_SHORT: assert property (@(posedge i_clk) disable iff (!rst_n)
        (in_cfg.mux == `UCS_MUX_SHORT && $stable(in_cfg.mux)) |=> o_inputs_shorted)
        else $error("inputs not shorted");
    AST_PIN2_DEFAULT: assert property (@(posedge i_clk) disable iff (!rst_n)
        !regs_q[4][`UCS_RESULT_READY_FLAG_SEL_BIT] |=> o_pin2_oe_n)
        else $error("pin2 driven while not selected");
    COV_WRITE: cover property (@(posedge i_clk) state_q == ST_WDATA && rx_valid);
    COV_READ: cover property (@(posedge i_clk) state_q == ST_RESP && resp_left_q == 2'd1);
    COV_CONV: cover property (@(posedge i_clk) conv_done);
    COV_SLEEP: cover property (@(posedge i_clk) o_sleep);
endmodule : ucs_sequencer

// ---- logic/ucs_uart.sv ----
// 8-n-1 uart receiver and transmitter
`timescale 1ns/1ps
`include "ucs_cfg.svh"
module ucs_uart (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_rx,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    input wire logic [7:0] i_tx_data,
    output logic o_tx
);
    logic [15:0] rx_cnt_q;
    logic [3:0] rx_bit_q;
    logic [8:0] rx_sh_q;
    logic rx_busy_q;
    logic [15:0] tx_cnt_q;
    logic [3:0] tx_bit_q;
    logic [9:0] tx_sh_q;
    // receiver: sample mid-bit, drop byte on bad stop bit
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_cnt_q <= 16'h0000;
            rx_bit_q <= 4'h0;
            rx_sh_q <= 9'h000;
            rx_busy_q <= 1'b0;
            o_rx_valid <= 1'b0;
            o_rx_data <= 8'h00;
        end else begin
            o_rx_valid <= 1'b0;
            if (!rx_busy_q) begin
                if (!i_rx) begin
                    rx_busy_q <= 1'b1;
                    rx_cnt_q <= `UCS_BAUD_DIV >> 1;
                    rx_bit_q <= 4'h0;
                end
            end else if (rx_cnt_q != 16'h0000) begin
                rx_cnt_q <= rx_cnt_q - 16'h0001;
            end else begin
                rx_cnt_q <= `UCS_BAUD_DIV - 16'h0001;
                rx_bit_q <= rx_bit_q + 4'h1;
                if (rx_bit_q == 4'h0) begin
                    if (i_rx) begin
                        rx_busy_q <= 1'b0; // glitch, not a start bit
                    end
                end else if (rx_bit_q == 4'h9) begin
                    rx_busy_q <= 1'b0;
                    o_rx_valid <= i_rx;
                    o_rx_data <= rx_sh_q[8:1];
                end else begin
                    rx_sh_q <= {i_rx, rx_sh_q[8:1]};
                end
            end
        end
    end
    assign o_tx_ready = (tx_bit_q == 4'h0);
    // transmitter: start, 8 data lsb first, one stop
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_cnt_q <= 16'h0000;
            tx_bit_q <= 4'h0;
            tx_sh_q <= 10'h3FF;
            o_tx <= 1'b1;
        end else if (tx_bit_q == 4'h0) begin
            if (i_tx_valid) begin
                tx_sh_q <= {1'b1, i_tx_data, 1'b0};
                tx_bit_q <= 4'hB; // extra cell keeps a full stop bit between bytes
                tx_cnt_q <= 16'h0000;
            end
        end else if (tx_cnt_q != 16'h0000) begin
            tx_cnt_q <= tx_cnt_q - 16'h0001;
        end else begin
            o_tx <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            tx_bit_q <= tx_bit_q - 4'h1;
            tx_cnt_q <= `UCS_BAUD_DIV - 16'h0001;
        end
    end
endmodule : ucs_uart
